// ---- shared/lsar_pkg.sv ----
`default_nettype none
package lsar_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ       = 40000;                   // Core clock rate in kHz
    localparam int T_CONV_STD_MS = 400;                     // Integration per channel, standard range
    localparam int T_CONV_EXT_MS = 80;                      // Integration per channel, extended range
    localparam int CONV_STD_CYC  = T_CONV_STD_MS * CLK_KHZ; // 16,000,000 cycles
    localparam int CONV_EXT_CYC  = T_CONV_EXT_MS * CLK_KHZ; // 3,200,000 cycles
    localparam int TIMER_W       = 24;                      // Holds the longest integration

    // ------------------------------------------------------------
    // Serial bus and command codes
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR    = 7'h39;           // Binary 0111001
    localparam logic [7:0] CMD_PWR_DOWN  = 8'h00;
    localparam logic [7:0] CMD_PWR_UP    = 8'h03;
    localparam logic [7:0] CMD_EXT_RANGE = 8'h1d;
    localparam logic [7:0] CMD_STD_RANGE = 8'h18;
    localparam logic [7:0] CMD_READ_CH0  = 8'h43;
    localparam logic [7:0] CMD_READ_CH1  = 8'h83;
    localparam logic [7:0] CMD_RESET     = CMD_PWR_DOWN;    // Command register after reset

    // ------------------------------------------------------------
    // Result format and companding
    // ------------------------------------------------------------
    localparam int COUNT_W        = 12;                     // Linear count from the integrator
    localparam int VALID_POS      = 7;
    localparam int CHORD_LSB      = 4;
    localparam int STEP_LSB       = 0;
    localparam int NUM_CHORDS     = 8;
    localparam int NUM_STEPS      = 16;
    localparam int CHORD_SCALE_X2 = 33;                     // Twice the 16.5 chord scale
    localparam logic [6:0] CODE_UNDER = 7'h00;              // Below detection limit
    localparam logic [6:0] CODE_OVER  = 7'h7f;              // Overflow

    typedef struct packed {
        logic       valid;
        logic [2:0] chord;
        logic [3:0] step;
    } lsar_result_t;
    localparam lsar_result_t RESULT_RESET = 8'h00;

    typedef enum logic [1:0] {SEL_CMD = 2'b00, SEL_CH0 = 2'b01, SEL_CH1 = 2'b10} lsar_sel_t;
    typedef enum logic {PH_CH0 = 1'b0, PH_CH1 = 1'b1} lsar_phase_t;
    typedef enum logic [2:0] {
        LK_ADDR  = 3'b000,
        LK_ACK_A = 3'b001,
        LK_WRITE = 3'b010,
        LK_ACK_W = 3'b011,
        LK_READ  = 3'b100,
        LK_RACK  = 3'b101,
        LK_IDLE  = 3'b110
    } lsar_link_t;

    // ------------------------------------------------------------
    // State carriers
    // ------------------------------------------------------------
    typedef struct packed {
        lsar_link_t state;
        logic [2:0] cnt;
        logic [7:0] shreg;
        logic [7:0] tx;
        logic       rd;
    } lsar_lpos_t;

    typedef struct packed {
        logic [7:0] byte_w;
        logic       tgl;
    } lsar_lwr_t;

    typedef struct packed {
        logic oe;
        logic pin_out;
    } lsar_lneg_t;

    typedef struct packed {
        logic               scl_m, scl_q, scl_h1, scl_h2;
        logic               sda_m, sda_q, sda_h;
        logic               wr_m, wr_q, wr_seen;
        logic [COUNT_W-1:0] cnt0_m, cnt0_q, cnt1_m, cnt1_q;
        logic               frame_open, hold, init;
        logic [7:0]         cmd;
        lsar_sel_t          sel;
        logic               powered, extended;
        lsar_result_t       res0, res1;
        lsar_phase_t        phase;
        logic [TIMER_W-1:0] timer;
        logic [7:0]         tx_word;
    } lsar_core_t;

endpackage
`default_nettype wire

// ---- rtl/lsar_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module lsar_top #(
    parameter int unsigned CONV_STD_CYC = lsar_pkg::CONV_STD_CYC,
    parameter int unsigned CONV_EXT_CYC = lsar_pkg::CONV_EXT_CYC
) (
    input  wire logic                         CLK,                      // Core clock, 40 MHz
    input  wire logic                         RST_B,                    // Synchronous reset, active low
    input  wire logic                         SERIAL_BUS_CLOCK_PIN,     // Link clock from the host
    input  wire logic                         SERIAL_BUS_DATA_PIN_IN,   // Data pin level
    output var  logic                         SERIAL_BUS_DATA_PIN_OUT,  // Data pin drive value
    output var  logic                         SERIAL_BUS_DATA_PIN_OE,   // Data pin pulled low when high
    input  wire logic [lsar_pkg::COUNT_W-1:0] CH0_COUNT,                // Integrated count, channel 0
    input  wire logic [lsar_pkg::COUNT_W-1:0] CH1_COUNT,                // Integrated count, channel 1
    output var  logic                         CONVERTER_ENABLE,         // Device powered and converting
    output var  logic                         EXTENDED_RANGE            // Extended range selected
);
    import lsar_pkg::*;

    // ------------------------------------------------------------
    // Constants and functions
    // ------------------------------------------------------------
    localparam logic [TIMER_W-1:0] STD_LAST = TIMER_W'(CONV_STD_CYC - 1);
    localparam logic [TIMER_W-1:0] EXT_LAST = TIMER_W'(CONV_EXT_CYC - 1);

    // Chord base count, the integer part of 16.5 * (2^C - 1)
    function automatic logic [COUNT_W-1:0] chord_base(input logic [2:0] c);
        logic [COUNT_W+5:0] prod;
        prod = (COUNT_W+6)'(CHORD_SCALE_X2) * (COUNT_W+6)'((1 << c) - 1);
        return COUNT_W'(prod >> 1);
    endfunction

    localparam logic [COUNT_W-1:0] COUNT_MAX =
        COUNT_W'(chord_base(3'(NUM_CHORDS - 1)) + (NUM_STEPS - 1) * (1 << (NUM_CHORDS - 1)));

    // Linear count to the seven-bit segmented code
    function automatic logic [6:0] compand(input logic [COUNT_W-1:0] n);
        logic [2:0]         c;
        logic [COUNT_W-1:0] rem;
        c = 3'h0;
        for (int i = 1; i < NUM_CHORDS; i++) begin
            if (n >= chord_base(3'(i))) begin
                c = 3'(i);
            end
        end
        rem = n - chord_base(c);
        if (n > COUNT_MAX) begin
            return CODE_OVER;
        end else if (n == '0) begin
            return CODE_UNDER;
        end
        return {c, 4'(rem >> c)};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam lsar_lpos_t LPOS_RESET = '{state: LK_ADDR, cnt: 3'h0, shreg: 8'h00, tx: 8'h00, rd: 1'b0};
    localparam lsar_core_t CORE_RESET = '{
        scl_m: 1'b1, scl_q: 1'b1, scl_h1: 1'b1, scl_h2: 1'b1,
        sda_m: 1'b1, sda_q: 1'b1, sda_h: 1'b1,
        wr_m: 1'b0, wr_q: 1'b0, wr_seen: 1'b0,
        cnt0_m: '0, cnt0_q: '0, cnt1_m: '0, cnt1_q: '0,
        frame_open: 1'b0, hold: 1'b1, init: 1'b1,
        cmd: CMD_RESET, sel: SEL_CMD, powered: 1'b0, extended: 1'b0,
        res0: RESULT_RESET, res1: RESULT_RESET, phase: PH_CH0,
        timer: '0, tx_word: CMD_RESET
    };

    lsar_lpos_t lpos, next_lpos;
    lsar_lwr_t  lwr, next_lwr;
    lsar_lneg_t lneg, next_lneg;
    lsar_core_t core, next_core;

    // ------------------------------------------------------------
    // Link domain, rising edge of the bus clock
    // ------------------------------------------------------------
    // Held in reset by the core whenever no frame is open, so each
    // start (or repeated start) begins cleanly at the address byte
    always_comb begin
        logic [7:0] byte_in;
        byte_in         = {lpos.shreg[6:0], SERIAL_BUS_DATA_PIN_IN};
        next_lpos       = lpos;
        next_lpos.shreg = byte_in;
        case (lpos.state)
            LK_ADDR: begin
                next_lpos.cnt = lpos.cnt + 3'h1;
                if (lpos.cnt == 3'h7) begin
                    if (byte_in[7:1] == SLAVE_ADDR) begin
                        next_lpos.state = LK_ACK_A;
                        next_lpos.rd    = byte_in[0];
                        next_lpos.tx    = core.tx_word;
                    end else begin
                        next_lpos.state = LK_IDLE;
                    end
                end
            end
            LK_ACK_A: begin
                next_lpos.cnt   = 3'h0;
                next_lpos.state = lpos.rd ? LK_READ : LK_WRITE;
            end
            LK_WRITE: begin
                next_lpos.cnt = lpos.cnt + 3'h1;
                if (lpos.cnt == 3'h7) begin
                    next_lpos.state = LK_ACK_W;
                end
            end
            LK_ACK_W: begin
                next_lpos.state = LK_IDLE;
            end
            LK_READ: begin
                next_lpos.cnt = lpos.cnt + 3'h1;
                if (lpos.cnt == 3'h7) begin
                    next_lpos.state = LK_RACK;
                end
            end
            LK_RACK: begin
                next_lpos.state = LK_IDLE;                          // Single byte per read
            end
            LK_IDLE: begin
                next_lpos.state = LK_IDLE;
            end
            default: begin
                next_lpos.state = LK_IDLE;
            end
        endcase
    end

    always_ff @(posedge SERIAL_BUS_CLOCK_PIN or posedge core.hold) begin
        if (core.hold) begin
            lpos <= LPOS_RESET;
        end else begin
            lpos <= next_lpos;
        end
    end

    // Written command byte with its event toggle; survives frame ends
    always_comb begin
        next_lwr = lwr;
        if (lpos.state == LK_WRITE && lpos.cnt == 3'h7) begin
            next_lwr.byte_w = {lpos.shreg[6:0], SERIAL_BUS_DATA_PIN_IN};
            next_lwr.tgl    = ~lwr.tgl;
        end
    end

    always_ff @(posedge SERIAL_BUS_CLOCK_PIN or posedge core.init) begin
        if (core.init) begin
            lwr <= '0;
        end else begin
            lwr <= next_lwr;
        end
    end

    // ------------------------------------------------------------
    // Link domain, falling edge: data pin drive
    // ------------------------------------------------------------
    // Changes only while the clock is low, as the bus demands
    always_comb begin
        next_lneg         = lneg;
        next_lneg.pin_out = 1'b0;
        case (lpos.state)
            LK_ACK_A: next_lneg.oe = 1'b1;                          // Acknowledge address
            LK_ACK_W: next_lneg.oe = 1'b1;                          // Acknowledge command
            LK_READ:  next_lneg.oe = ~lpos.tx[~lpos.cnt];           // MSB first
            default:  next_lneg.oe = 1'b0;
        endcase
    end

    always_ff @(negedge SERIAL_BUS_CLOCK_PIN or posedge core.hold) begin
        if (core.hold) begin
            lneg <= '0;
        end else begin
            lneg <= next_lneg;
        end
    end

    // ------------------------------------------------------------
    // Core domain: synchronisers and frame detection
    // ------------------------------------------------------------
    always_comb begin
        logic scl_steady;
        logic start_det;
        logic stop_det;
        next_core        = core;
        next_core.init   = 1'b0;
        next_core.scl_m  = SERIAL_BUS_CLOCK_PIN;
        next_core.scl_q  = core.scl_m;
        next_core.scl_h1 = core.scl_q;
        next_core.scl_h2 = core.scl_h1;
        next_core.sda_m  = SERIAL_BUS_DATA_PIN_IN;
        next_core.sda_q  = core.sda_m;
        next_core.sda_h  = core.sda_q;
        next_core.wr_m   = lwr.tgl;
        next_core.wr_q   = core.wr_m;
        next_core.cnt0_m = CH0_COUNT;
        next_core.cnt0_q = core.cnt0_m;
        next_core.cnt1_m = CH1_COUNT;
        next_core.cnt1_q = core.cnt1_m;

        // Three high samples in a row: a data edge then is a start or stop
        scl_steady = core.scl_q & core.scl_h1 & core.scl_h2;
        start_det  = scl_steady & core.sda_h & ~core.sda_q;
        stop_det   = scl_steady & ~core.sda_h & core.sda_q;
        if (start_det) begin
            next_core.frame_open = 1'b1;
        end else if (stop_det) begin
            next_core.frame_open = 1'b0;
        end
        next_core.hold = start_det | ~next_core.frame_open;

        // Conversion sequencer: channel 0 then channel 1, endlessly
        if (core.powered) begin
            if (core.timer == (core.extended ? EXT_LAST : STD_LAST)) begin
                next_core.timer = '0;
                if (core.phase == PH_CH0) begin
                    next_core.res0  = {1'b1, compand(core.cnt0_q)};
                    next_core.phase = PH_CH1;
                end else begin
                    next_core.res1  = {1'b1, compand(core.cnt1_q)};
                    next_core.phase = PH_CH0;
                end
            end else begin
                next_core.timer = core.timer + 1'b1;
            end
        end

        // Command taken once the written byte has settled across domains
        if (core.wr_q != core.wr_seen) begin
            next_core.wr_seen = core.wr_q;
            next_core.cmd     = lwr.byte_w;
            case (lwr.byte_w)
                CMD_PWR_DOWN: begin
                    next_core.powered     = 1'b0;
                    next_core.extended    = 1'b0;
                    next_core.timer       = '0;
                    next_core.res0.valid  = 1'b0;
                    next_core.res1.valid  = 1'b0;
                end
                CMD_PWR_UP:    next_core.sel = SEL_CMD;
                CMD_READ_CH0:  next_core.sel = SEL_CH0;
                CMD_READ_CH1:  next_core.sel = SEL_CH1;
                CMD_EXT_RANGE: next_core.extended = 1'b1;
                CMD_STD_RANGE: next_core.extended = 1'b0;
                default:       next_core.sel = core.sel;
            endcase
            // Leaving power-down restarts from channel 0 with nothing valid
            if (!core.powered && (lwr.byte_w == CMD_PWR_UP || lwr.byte_w == CMD_READ_CH0 ||
                                  lwr.byte_w == CMD_READ_CH1)) begin
                next_core.powered    = 1'b1;
                next_core.phase      = PH_CH0;
                next_core.timer      = '0;
                next_core.res0.valid = 1'b0;
                next_core.res1.valid = 1'b0;
            end
        end

        // Read word frozen while a frame is open so the link sees it steady
        if (!core.frame_open && !start_det) begin
            case (core.sel)
                SEL_CH0: next_core.tx_word = core.res0;
                SEL_CH1: next_core.tx_word = core.res1;
                default: next_core.tx_word = core.cmd;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            core <= CORE_RESET;
        end else begin
            core <= next_core;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        SERIAL_BUS_DATA_PIN_OUT = lneg.pin_out;
        SERIAL_BUS_DATA_PIN_OE  = lneg.oe;
        CONVERTER_ENABLE        = core.powered;
        EXTENDED_RANGE          = core.extended;
    end

endmodule
`default_nettype wire

// ---- verification/lsar_top_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module lsar_top_sva (
    input wire logic CLK,                     // Core clock
    input wire logic RST_B,                   // Sync reset, active low
    input wire logic SERIAL_BUS_CLOCK_PIN,    // Bus clock
    input wire logic SERIAL_BUS_DATA_PIN_OUT, // Data drive value
    input wire logic SERIAL_BUS_DATA_PIN_OE,  // Data pulled low when high
    input wire logic CONVERTER_ENABLE,        // Powered and converting
    input wire logic EXTENDED_RANGE           // Extended range
);
    // ------------------------------------------------------------
    // Bus idle counter
    // ------------------------------------------------------------
    logic [7:0] idle_cnt;
    logic [7:0] next_idle_cnt;

    // Cycles with the bus clock high; saturates so a long idle stays idle
    always_comb begin
        next_idle_cnt = idle_cnt;
        if (!RST_B || !SERIAL_BUS_CLOCK_PIN) begin
            next_idle_cnt = 8'h00;
        end else if (idle_cnt != 8'hff) begin
            next_idle_cnt = idle_cnt + 8'h01;
        end
    end

    always_ff @(posedge CLK) begin
        idle_cnt <= next_idle_cnt;
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence s_frame_near;
        idle_cnt < 8'h14;
    endsequence
    sequence s_bus_quiet;
        idle_cnt > 8'h14;
    endsequence

    a_reset_quiet: assert property ($rose(RST_B) |-> !CONVERTER_ENABLE && !EXTENDED_RANGE)
        else $error("converter active right after reset");
    a_reset_link: assert property ($rose(RST_B) |-> !SERIAL_BUS_DATA_PIN_OE)
        else $error("data pin pulled right after reset");
    a_out_low: assert property (SERIAL_BUS_DATA_PIN_OUT == 1'b0)
        else $error("data pin drive value not low");
    a_oe_idle_low: assert property (s_bus_quiet |-> !SERIAL_BUS_DATA_PIN_OE)
        else $error("data pin pulled while bus idle");
    a_enable_by_cmd: assert property ($changed(CONVERTER_ENABLE) |-> s_frame_near)
        else $error("power state moved outside a frame");
    a_range_by_cmd: assert property ($changed(EXTENDED_RANGE) |-> s_frame_near)
        else $error("range moved outside a frame");
    a_range_cleared: assert property ($fell(CONVERTER_ENABLE) |-> ##[0:2] !EXTENDED_RANGE)
        else $error("extended range kept after power down");
    // Longest pull is acknowledge plus eight zero bits; the host slot after it must be free
    a_oe_released: assert property (@(posedge SERIAL_BUS_CLOCK_PIN) disable iff (!RST_B)
        SERIAL_BUS_DATA_PIN_OE [*8] |-> ##2 !SERIAL_BUS_DATA_PIN_OE)
        else $error("data pin held too long");
endmodule
bind lsar_top lsar_top_sva lsar_top_sva_inst (.CLK(CLK), .RST_B(RST_B),
    .SERIAL_BUS_CLOCK_PIN(SERIAL_BUS_CLOCK_PIN), .SERIAL_BUS_DATA_PIN_OUT(SERIAL_BUS_DATA_PIN_OUT),
    .SERIAL_BUS_DATA_PIN_OE(SERIAL_BUS_DATA_PIN_OE), .CONVERTER_ENABLE(CONVERTER_ENABLE),
    .EXTENDED_RANGE(EXTENDED_RANGE));
`default_nettype wire

// ---- verification/lsar_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module lsar_host (
    output var logic scl,     // Bus clock, stands high between frames
    output var logic sda_low, // Host pulls the data wire low
    input wire logic sda      // Resolved data wire
);
    logic [7:0] rx = 8'h00;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // One bit: data moves while the clock is low, sampled mid-high
    task automatic bit_cycle(input logic b);
        scl = 1'b0;
        #12;
        sda_low = !b;
        #12;
        scl = 1'b1;
        #12;
        rx = {rx[6:0], sda};
        #12;
    endtask

    // One-byte transaction; on a read the host releases the wire and NACKs
    task automatic frame(input logic [7:0] addr, input logic [7:0] data,
                         output logic [7:0] got, output logic [1:0] acks);
        #7;
        sda_low = 1'b1;
        #200;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(addr[i]);
        end
        bit_cycle(1'b1);
        acks[1] = !rx[0];
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(addr[0] || data[i]);
        end
        got = rx;
        bit_cycle(1'b1);
        acks[0] = !rx[0];
        // STOP with long clock-high margins so the core sees it
        scl = 1'b0;
        #12;
        sda_low = 1'b1;
        #12;
        scl = 1'b1;
        #200;
        sda_low = 1'b0;
        #200;
    endtask
endmodule
`default_nettype wire

// ---- verification/lsar_top_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module lsar_top_tb_top;
    import lsar_pkg::*;
    localparam int STD = 400;
    localparam int EXT = 80;
    logic               clk = 1'b0;
    logic               rst_b;
    logic [COUNT_W-1:0] ch0_count;
    logic [COUNT_W-1:0] ch1_count;
    logic               scl;
    logic               sda_low;
    logic               sda;
    logic               oe;
    logic               out;
    logic               enable;
    logic               ext_range;
    int                 fails = 0;
    int                 comparisons = 0;
    int                 cycles = 0;
    logic [6:0]         codes [6] = '{7'h00, 7'h10, 7'h23, 7'h55, 7'h70, 7'h7f};

    // Open-drain data wire with pull-up
    assign sda = !((oe && !out) || sda_low);

    lsar_top #(.CONV_STD_CYC(STD), .CONV_EXT_CYC(EXT)) lsar_top_inst (.CLK(clk), .RST_B(rst_b),
        .SERIAL_BUS_CLOCK_PIN(scl), .SERIAL_BUS_DATA_PIN_IN(sda), .SERIAL_BUS_DATA_PIN_OUT(out),
        .SERIAL_BUS_DATA_PIN_OE(oe), .CH0_COUNT(ch0_count), .CH1_COUNT(ch1_count),
        .CONVERTER_ENABLE(enable), .EXTENDED_RANGE(ext_range));
    lsar_host lsar_host_inst (.scl(scl), .sda_low(sda_low), .sda(sda));

    always #12.5 clk = !clk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic send(input logic [7:0] cmd);
        logic [7:0] got;
        logic [1:0] acks;
        @(negedge clk);
        lsar_host_inst.frame({SLAVE_ADDR, 1'b0}, cmd, got, acks);
        check_byte({6'h00, acks}, 8'h03);
    endtask
    task automatic read(output logic [7:0] got);
        logic [1:0] acks;
        @(negedge clk);
        lsar_host_inst.frame({SLAVE_ADDR, 1'b1}, 8'hff, got, acks);
        check_bit(acks[1], 1'b1);
    endtask
    // Linear count for a code; overflow is pushed past the top of the last chord
    function automatic logic [COUNT_W-1:0] count_of(input logic [6:0] code);
        if (code == CODE_OVER) return 12'hfff;
        return COUNT_W'((33 * ((1 << code[6:4]) - 1)) / 2 + code[3:0] * (1 << code[6:4]));
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_power_on;
        logic [7:0] d;
        check_bit(enable, 1'b0);
        check_bit(ext_range, 1'b0);
        read(d);
        check_byte(d, CMD_RESET);
        send(CMD_PWR_UP);
        check_bit(enable, 1'b1);
        read(d);
        check_byte(d, CMD_PWR_UP);
    endtask
    // Power-up restarts the timer at channel 0, so every read lands before the next write
    task automatic t_codes(input int k);
        logic [7:0] d;
        send(CMD_PWR_DOWN);
        check_bit(enable, 1'b0);
        @(negedge clk);
        ch0_count = count_of(codes[k]);
        ch1_count = count_of(codes[5 - k]);
        send(CMD_READ_CH0);
        check_bit(enable, 1'b1);
        read(d);
        check_bit(d[VALID_POS], 1'b0);
        repeat (2 * STD - 40) @(negedge clk);
        read(d);
        check_byte(d, {1'b1, codes[k]});
        ch0_count = ~ch0_count;
        read(d);
        check_byte(d, {1'b1, codes[k]});
        send(CMD_READ_CH1);
        read(d);
        check_byte(d, {1'b1, codes[5 - k]});
    endtask
    task automatic t_wrong_addr;
        logic [7:0] got;
        logic [1:0] acks;
        @(negedge clk);
        lsar_host_inst.frame({SLAVE_ADDR ^ 7'h01, 1'b0}, CMD_PWR_DOWN, got, acks);
        check_byte({6'h00, acks}, 8'h00);
        check_bit(enable, 1'b1);
    endtask
    // Extended range must bring the first channel 0 result in well before the standard time would
    task automatic t_range;
        logic [7:0] d;
        send(CMD_PWR_DOWN);
        @(negedge clk);
        ch0_count = count_of(codes[3]);
        send(CMD_READ_CH0);
        send(CMD_EXT_RANGE);
        check_bit(ext_range, 1'b1);
        repeat (20) @(negedge clk);
        read(d);
        check_byte(d, {1'b1, codes[3]});
        send(CMD_EXT_RANGE);
        check_bit(ext_range, 1'b1);
        send(CMD_READ_CH0);
        check_bit(ext_range, 1'b1);
        send(CMD_STD_RANGE);
        check_bit(ext_range, 1'b0);
        send(CMD_EXT_RANGE);
        send(CMD_PWR_DOWN);
        check_bit(enable, 1'b0);
        check_bit(ext_range, 1'b0);
    endtask

    // Hang guard, about two and a half times the expected run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        rst_b = 1'b0;
        ch0_count = '0;
        ch1_count = '0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        t_power_on();
        for (int k = 0; k < 6; k++) begin
            t_codes(k);
        end
        t_wrong_addr();
        t_range();
        give_verdict();
    end
endmodule
`default_nettype wire
